// File: pef_far.sv
/* Far-side pins and timer channels.
 Assumes the pin outputs of pef_top. */
`timescale 1ns/10ps
module pef_far (input wire logic i_sys_clk, input wire logic [15:0] i_out, input wire logic [15:0] i_oe,
	output logic [15:0] o_pin, output logic [15:0] o_cmp);
	logic [15:0] ext_ff = 16'h0f0f;
	// Released pins toggle so a stale level never passes
	always_ff @(posedge i_sys_clk) ext_ff <= ~ext_ff;
	assign o_pin = (i_oe & i_out) | (~i_oe & ext_ff);
	assign o_cmp = ~ext_ff;
endmodule

// File: pef_pin_cell.sv
/*
 Function steering for one port pin.
 Assumes mode and direction come from the next values of the registers, not the stored ones; purely combinational.
*/
`timescale 1ns/10ps
module pef_pin_cell (
	input wire logic [1:0] i_mode,
	input wire logic i_timer_dir,
	input wire logic i_pin_level,
	input wire logic i_port_data,
	input wire logic i_timer_cmp,
	output logic o_drive,
	output logic o_oe,
	output logic o_port_in,
	output logic o_capt_in
);

	logic is_gpio_in;
	logic is_gpio_out;
	logic is_timer;
	logic timer_out;
	logic timer_in;

	assign is_gpio_in = (i_mode == pef_pkg::MODE_GPIO_IN); // RULE3
	assign is_gpio_out = (i_mode == pef_pkg::MODE_GPIO_OUT); // RULE3
	assign is_timer = (i_mode == pef_pkg::MODE_TIMER); // RULE5
	// Direction bit only counts in timer mode
	assign timer_out = is_timer & (i_timer_dir == pef_pkg::DIR_OUTPUT); // RULE6 RULE10 RULE11
	assign timer_in = is_timer & (i_timer_dir != pef_pkg::DIR_OUTPUT); // RULE11

	// Reserved code falls through with the driver off, the safest pad state
	assign o_oe = is_gpio_out | timer_out; // RULE13
	assign o_drive = is_gpio_out ? i_port_data : (timer_out & i_timer_cmp); // RULE14 RULE11
	assign o_port_in = is_gpio_in & i_pin_level; // RULE13
	assign o_capt_in = timer_in & i_pin_level; // RULE13

endmodule

// File: pef_pkg.sv
/*
 Constants, types and shared functions for the port E pin-function select block.
 Assumes a 32-bit APB slave port with byte addresses and a single 40 MHz clock.
*/
// Notes on behaviour
// RULE1 - 32-bit read/write function-select register, every bit reads back as written.
// RULE2 - Pin n owns mode bits 2n+1 and 2n of function-select.
// RULE3 - Mode 00 makes the pin a general input, 01 a general output.
// RULE4 - Software must never write reserved mode 10.
// RULE5 - Mode 11 routes the pin to its timer channel function.
// RULE6 - In mode 11 the direction comes from the direction register bit.
// RULE7 - Power-on reset clears function-select, all pins start as general inputs.
// RULE8 - Both registers hold through manual reset, standby and sleep.
// RULE9 - 16-bit read/write direction register, bit n controls pin n.
// RULE10 - Direction bit is ignored unless its pin is in timer mode.
// RULE11 - Timer mode: direction 1 drives compare output, 0 feeds input capture.
// RULE12 - Power-on reset clears direction register, timer pins default to input.
// RULE13 - Input modes keep driver off and pass pin level to consumer.
// RULE14 - General output drives pin from the external port data bit.
package pef_pkg;

	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam int NUM_PINS = 16;
	localparam int MODE_W = 2;
	localparam int ADDR_W = 12;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [11:0] ADDR_FUNC_SEL = 12'h000;
	localparam logic [11:0] ADDR_TIMER_DIR = 12'h004;
	localparam logic [11:0] ADDR_PIN_LEVEL = 12'h008;
	localparam logic [11:0] ADDR_EFF_DIR = 12'h00c;
	localparam logic [11:0] ADDR_RSVD_MODE = 12'h010;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [31:0] FUNC_SEL_RESET = 32'h0000_0000;
	localparam logic [15:0] TIMER_DIR_RESET = 16'h0000;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	// ----------------------------------------
	// Mode field codes
	// ----------------------------------------
	localparam logic [1:0] MODE_GPIO_IN = 2'h0;
	localparam logic [1:0] MODE_GPIO_OUT = 2'h1;
	localparam logic [1:0] MODE_RESERVED = 2'h2;
	localparam logic [1:0] MODE_TIMER = 2'h3;
	localparam logic DIR_OUTPUT = 1'b1;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_RESP = 2'b10
	} pef_bus_state_type;

	// Mode field of one pin
	function automatic logic [1:0] pin_mode(input logic [31:0] sel, input int pin);
		pin_mode = sel[MODE_W*pin +: MODE_W]; // RULE2
	endfunction

	// Byte-lane merge of an APB write
	function automatic logic [31:0] strobe_merge(input logic [31:0] old_word, input logic [31:0] wdata,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old_word;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = wdata[8*b +: 8];
			end
		end
		strobe_merge = res;
	endfunction

endpackage

// File: pef_props.sv
/* Port checker for pef_top.
 Assumes a bind from the bench top. */
`timescale 1ns/10ps
module pef_props (
	input wire logic i_sys_clk, input wire logic i_srst, input wire logic i_psel, input wire logic i_penable,
	input wire logic i_pwrite, input wire logic [11:0] i_paddr, input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb, input wire logic o_pready, input wire logic [15:0] i_port_data,
	input wire logic [15:0] o_pin_out, input wire logic [15:0] o_pin_oe
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	// Whole-word write of function-select that completes at this edge
	wire wr = i_psel && i_penable && o_pready && i_pwrite && i_pstrb == 4'hf && i_paddr == pef_pkg::ADDR_FUNC_SEL;
	AST_RST: assert property (disable iff (1'b0) i_srst |=> o_pin_oe == 16'h0000) else $error("oe after reset");
	AST_OUT: assert property (wr && i_pwdata == 32'h5555_5555 |=> o_pin_oe == 16'hffff) else $error("oe off");
	AST_IN: assert property (wr && i_pwdata == 32'h0000_0000 |=> o_pin_oe == 16'h0000) else $error("oe on");
	AST_DATA: assert property (wr && i_pwdata == 32'h5555_5555 |=> o_pin_out == i_port_data) else $error("data");
	AST_PAIR: assert property (wr && i_pwdata == 32'h4000_0001 |=> o_pin_oe == 16'h8001) else $error("field");
	AST_IGN: assert property (wr && i_pwdata == 32'h0000_000c |=> o_pin_oe == 16'h0002) else $error("dir");
	AST_HOLD: assert property (!i_psel |=> $stable(o_pin_oe)) else $error("oe moved");
	AST_RDY: assert property (i_psel && !i_penable |-> ##[1:16] o_pready) else $error("no answer");
	cover property (wr && i_pwdata == 32'hffff_ffff);
	cover property (o_pin_oe == 16'h0002);
	cover property (i_psel && i_penable && o_pready && !i_pwrite);
endmodule

// File: pef_rw_reg.sv
/*
 One software read/write register with APB byte strobes.
 Assumes the caller gates the write enable to the completing access phase.
*/
`timescale 1ns/10ps
module pef_rw_reg #(
	parameter int WIDTH = 32,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic i_wr_en,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_strb,
	output logic [WIDTH-1:0] o_value
);

	logic [WIDTH-1:0] value_ff;
	logic [31:0] old_word;
	logic [31:0] merged;
	logic [WIDTH-1:0] nxt_value;

	assign old_word = 32'(value_ff);
	assign merged = pef_pkg::strobe_merge(old_word, i_wdata, i_strb);
	assign nxt_value = i_wr_en ? merged[WIDTH-1:0] : value_ff;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// Only power-on reset clears; manual reset and low-power states never reach here
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			value_ff <= RESET_VALUE; // RULE7 RULE12
		end else begin
			value_ff <= nxt_value; // RULE8
		end
	end

	assign o_value = value_ff;

endmodule

// File: pef_top.sv
/*
 Port E pin-function select: APB register file and per-pin steering.
 Assumes an APB master on i_sys_clk, pins sampled synchronously, and port data
 register plus timer unit outside this block.
*/
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module pef_top #(
	parameter int NUM_PINS = pef_pkg::NUM_PINS
) (
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic i_manual_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic [15:0] i_pin_in,
	input wire logic [15:0] i_port_data,
	input wire logic [15:0] i_timer_cmp_out,
	output logic [15:0] o_pin_out,
	output logic [15:0] o_pin_oe,
	output logic [15:0] o_port_in,
	output logic [15:0] o_timer_capt_in
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	// Bus handshake
	pef_pkg::pef_bus_state_type bus_state_ff;
	pef_pkg::pef_bus_state_type nxt_bus_state;
	logic pready_ff;
	logic nxt_pready;
	logic pslverr_ff;
	logic nxt_pslverr;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic bus_rst;
	logic access_wait;
	logic access_done;
	logic enter_resp;

	// Address decode
	logic hit_func_sel;
	logic hit_timer_dir;
	logic hit_eff_dir;
	logic addr_ok;
	logic wr_func_sel;
	logic wr_timer_dir;
	logic [31:0] read_word;

	// Register contents and their next values
	logic [31:0] func_sel;
	logic [15:0] timer_dir;
	logic [31:0] func_sel_merge;
	logic [31:0] timer_dir_merge;
	logic [31:0] func_sel_nxt;
	logic [15:0] timer_dir_nxt;

	// Per-pin steering
	logic [15:0] cell_drive;
	logic [15:0] cell_oe;
	logic [15:0] cell_port_in;
	logic [15:0] cell_capt_in;

	// Registered pin outputs
	logic [15:0] pin_out_ff;
	logic [15:0] nxt_pin_out;
	logic [15:0] pin_oe_ff;
	logic [15:0] nxt_pin_oe;
	logic [15:0] port_in_ff;
	logic [15:0] nxt_port_in;
	logic [15:0] capt_in_ff;
	logic [15:0] nxt_capt_in;

	// ----------------------------------------
	// Bus phase decode
	// ----------------------------------------
	// Manual reset only restarts the handshake; the registers must survive it
	assign bus_rst = i_srst | i_manual_rst;
	assign access_wait = i_psel & i_penable & ~pready_ff;
	assign access_done = i_psel & i_penable & pready_ff;
	assign enter_resp = (bus_state_ff == pef_pkg::BUS_IDLE) & access_wait;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	assign hit_func_sel = (i_paddr == pef_pkg::ADDR_FUNC_SEL);
	assign hit_timer_dir = (i_paddr == pef_pkg::ADDR_TIMER_DIR);
	assign hit_eff_dir = (i_paddr == pef_pkg::ADDR_EFF_DIR);
	// Effective direction is a status word; a write to it is refused
	assign addr_ok = hit_func_sel | hit_timer_dir | (hit_eff_dir & ~i_pwrite);
	assign wr_func_sel = access_done & i_pwrite & hit_func_sel; // RULE1
	assign wr_timer_dir = access_done & i_pwrite & hit_timer_dir; // RULE9

	// ----------------------------------------
	// Read selection
	// ----------------------------------------
	always_comb begin
		read_word = pef_pkg::READ_ZERO;
		if (hit_func_sel) begin
			read_word = func_sel; // RULE1
		end else if (hit_timer_dir) begin
			read_word = {16'h0000, timer_dir}; // RULE9
		end else if (hit_eff_dir) begin
			read_word = {16'h0000, pin_oe_ff};
		end else begin
			read_word = pef_pkg::READ_ZERO;
		end
	end

	// ----------------------------------------
	// Bus state machine
	// ----------------------------------------
	// One wait state: pready rises in the cycle after the access phase starts
	always_comb begin
		nxt_bus_state = bus_state_ff;
		case (bus_state_ff)
			pef_pkg::BUS_IDLE: begin
				if (access_wait) begin
					nxt_bus_state = pef_pkg::BUS_RESP;
				end
			end
			pef_pkg::BUS_RESP: begin
				nxt_bus_state = pef_pkg::BUS_IDLE;
			end
			default: begin
				nxt_bus_state = pef_pkg::BUS_IDLE;
			end
		endcase
	end

	assign nxt_pready = (nxt_bus_state == pef_pkg::BUS_RESP);
	assign nxt_pslverr = enter_resp & ~addr_ok;
	// Read data is captured once and stands through the response cycle
	assign nxt_prdata = enter_resp ? read_word : prdata_ff;

	always_ff @(posedge i_sys_clk) begin
		if (bus_rst) begin
			bus_state_ff <= pef_pkg::BUS_IDLE;
		end else begin
			bus_state_ff <= nxt_bus_state;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (bus_rst) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (bus_rst) begin
			prdata_ff <= pef_pkg::READ_ZERO;
		end else begin
			prdata_ff <= nxt_prdata;
		end
	end

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	pef_rw_reg #(
		.WIDTH(32),
		.RESET_VALUE(pef_pkg::FUNC_SEL_RESET)
	) u_func_sel (
		.i_sys_clk(i_sys_clk),
		.i_srst(i_srst),
		.i_wr_en(wr_func_sel),
		.i_wdata(i_pwdata),
		.i_strb(i_pstrb),
		.o_value(func_sel)
	); // RULE1 RULE7 RULE8

	pef_rw_reg #(
		.WIDTH(16),
		.RESET_VALUE(pef_pkg::TIMER_DIR_RESET)
	) u_timer_dir (
		.i_sys_clk(i_sys_clk),
		.i_srst(i_srst),
		.i_wr_en(wr_timer_dir),
		.i_wdata(i_pwdata),
		.i_strb(i_pstrb),
		.o_value(timer_dir)
	); // RULE9 RULE12 RULE8

	// ----------------------------------------
	// Next register values
	// ----------------------------------------
	// Pins follow the value being written, so they settle with the register
	assign func_sel_merge = pef_pkg::strobe_merge(func_sel, i_pwdata, i_pstrb);
	assign timer_dir_merge = pef_pkg::strobe_merge({16'h0000, timer_dir}, i_pwdata, i_pstrb);
	assign func_sel_nxt = wr_func_sel ? func_sel_merge : func_sel;
	assign timer_dir_nxt = wr_timer_dir ? timer_dir_merge[15:0] : timer_dir;

	// ----------------------------------------
	// Per-pin steering
	// ----------------------------------------
	// Ports are sixteen wide; NUM_PINS above 16 is not supported
	for (genvar pin = 0; pin < NUM_PINS; pin++) begin : g_pin
		pef_pin_cell u_cell (
			.i_mode(pef_pkg::pin_mode(func_sel_nxt, pin)), // RULE2
			.i_timer_dir(timer_dir_nxt[pin]), // RULE6
			.i_pin_level(i_pin_in[pin]),
			.i_port_data(i_port_data[pin]),
			.i_timer_cmp(i_timer_cmp_out[pin]),
			.o_drive(cell_drive[pin]),
			.o_oe(cell_oe[pin]),
			.o_port_in(cell_port_in[pin]),
			.o_capt_in(cell_capt_in[pin])
		);
	end

	assign nxt_pin_out = cell_drive;
	assign nxt_pin_oe = cell_oe;
	assign nxt_port_in = cell_port_in;
	assign nxt_capt_in = cell_capt_in;

	// ----------------------------------------
	// Registered pin outputs
	// ----------------------------------------
	// A pin's driver must be off while reset holds; inputs is the safe default
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			pin_oe_ff <= 16'h0000; // RULE7
			pin_out_ff <= 16'h0000;
		end else begin
			pin_oe_ff <= nxt_pin_oe; // RULE13
			pin_out_ff <= nxt_pin_out; // RULE14
		end
	end

	// Consumers see the pin one cycle late, the cost of registered outputs
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			port_in_ff <= 16'h0000;
			capt_in_ff <= 16'h0000;
		end else begin
			port_in_ff <= nxt_port_in; // RULE13
			capt_in_ff <= nxt_capt_in; // RULE11
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_prdata = prdata_ff;
	assign o_pready = pready_ff;
	assign o_pslverr = pslverr_ff;
	assign o_pin_out = pin_out_ff;
	assign o_pin_oe = pin_oe_ff;
	assign o_port_in = port_in_ff;
	assign o_timer_capt_in = capt_in_ff;

endmodule

// File: pef_top_tb.sv
/* Bench for pef_top.
 Assumes the far-side model and the checker. */
`timescale 1ns/10ps
module pef_top_tb;
	logic clk = 0, srst = 1, mrst = 0, psel = 0, pen = 0, pwr = 0, rdy;
	logic [11:0] adr = 12'h000;
	logic [31:0] wd = 32'h0000_0000, rdat, r;
	logic [15:0] pin, cmp, pout, poe, pdat = 16'hbc5b, pin_in_seen, capt_seen;
	logic err, serr;
	int mismatches = 0, tests_run = 0, cyc = 0;
	localparam logic [11:0] FS = pef_pkg::ADDR_FUNC_SEL, DR = pef_pkg::ADDR_TIMER_DIR;
	pef_top dut (.i_sys_clk(clk), .i_srst(srst), .i_manual_rst(mrst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(adr), .i_pwdata(wd), .i_pstrb(4'hf), .o_prdata(rdat), .o_pready(rdy), .o_pslverr(err), .i_pin_in(pin),
		.i_port_data(pdat), .i_timer_cmp_out(cmp), .o_pin_out(pout), .o_pin_oe(poe), .o_port_in(pin_in_seen),
		.o_timer_capt_in(capt_seen));
	pef_far far (.i_sys_clk(clk), .i_out(pout), .i_oe(poe), .o_pin(pin), .o_cmp(cmp));
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc > 2000) begin
			mismatches++;
			complete_run;
		end
	end
	task automatic complete_run;
		if (mismatches == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// Request held until pready is seen high at a rising edge, then released there
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwr <= w;
		adr <= a;
		wd <= d;
		@(posedge clk);
		pen <= 1;
		do @(posedge clk); while (rdy !== 1'b1);
		r = rdat;
		serr = err;
		psel <= 0;
		pen <= 0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(0, a, 32'h0000_0000);
		chk(r, e);
		chk(32'(serr), 32'h0000_0000);
	endtask
	// Pin outputs are registered, so they show the far side one cycle late
	task automatic lag(input int k);
		logic [15:0] c;
		logic [15:0] p;
		@(negedge clk);
		c = cmp;
		p = pin;
		@(negedge clk);
		if (k == 0)
			chk(32'(pout), 32'(c));
		else if (k == 1)
			chk(32'(pin_in_seen), 32'(p));
		else
			chk(32'(capt_seen), 32'(p));
	endtask
	task automatic pins(input logic [15:0] e);
		@(negedge clk);
		chk(poe, e);
	endtask
	task automatic t_reset;
		rd(FS, 32'h0000_0000);
		rd(DR, 32'h0000_0000);
		pins(16'h0000);
		lag(1);
	endtask
	task automatic t_gpio;
		apb(1, FS, 32'h5555_5555);
		rd(FS, 32'h5555_5555);
		pins(16'hffff);
		chk(pout, pdat);
	endtask
	task automatic t_timer;
		apb(1, DR, 32'h0000_ffff);
		apb(1, FS, 32'hffff_ffff);
		rd(DR, 32'h0000_ffff);
		pins(16'hffff);
		lag(0);
		apb(1, DR, 32'h0000_0000);
		pins(16'h0000);
		lag(2);
	endtask
	task automatic t_mix;
		apb(1, FS, 32'h0000_0000);
		pins(16'h0000);
		apb(1, FS, 32'h4000_0001);
		pins(16'h8001);
		apb(1, DR, 32'h0000_ffff);
		apb(1, FS, 32'h0000_000c);
		pins(16'h0002);
		rd(pef_pkg::ADDR_EFF_DIR, 32'h0000_0002);
	endtask
	task automatic t_hold;
		@(posedge clk) mrst <= 1;
		@(posedge clk) mrst <= 0;
		apb(0, 12'h100, 32'h0000_0000);
		chk(32'(serr), 32'h0000_0001);
		rd(FS, 32'h0000_000c);
		rd(DR, 32'h0000_ffff);
		@(posedge clk) srst <= 1;
		repeat (4) @(posedge clk);
		srst <= 0;
		t_reset;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		srst <= 0;
		t_reset;
		t_gpio;
		t_timer;
		t_mix;
		t_hold;
		complete_run;
	end
endmodule
bind pef_top pef_props props (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_pready(o_pready),
	.i_port_data(i_port_data), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe));
